// ===== common/exarb_pkg.sv
/*
  Shared constants and types for the external bus arbitration block.
  Assumes one 125 MHz core clock and active-low wired lines on the bus.
*/
package exarb_pkg;
  localparam int          EXARB_NUM_PEERS   = 8;
  localparam int          EXARB_ID_W        = 3;
  localparam logic [2:0]  EXARB_ID_ZERO     = 3'h0;
  localparam logic [3:0]  EXARB_LOCAL_SPACE = 4'h0;
  localparam int          EXARB_HOST_MSB    = 31;
  localparam int          EXARB_HOST_LSB    = 28;
  localparam logic [7:0]  EXARB_REQ_IDLE    = 8'hFF;
  localparam int          EXARB_SREF_CYCLES = 4;
  localparam logic [2:0]  EXARB_SREF_CNT_W3 = 3'h4;

  typedef enum logic [5:0] {
    EXARB_IDLE   = 6'h01,
    EXARB_OWN    = 6'h02,
    EXARB_SREF   = 6'h04,
    EXARB_HOSTED = 6'h08,
    EXARB_YIELD  = 6'h10,
    EXARB_WAIT   = 6'h20
  } exarb_state_t;

  // Host space decode of an address
  function automatic logic exarb_is_host_space(input logic [31:0] addr);
    return addr[EXARB_HOST_MSB:EXARB_HOST_LSB] != EXARB_LOCAL_SPACE;
  endfunction

  // Priority winner among low-active requests, rotating after last owner
  function automatic logic [2:0] exarb_next_owner(input logic [7:0] req_n, input logic [2:0] last);
    logic [2:0] idx;
    logic [2:0] win;
    win = last;
    for (int i = 8; i >= 1; i--) begin
      idx = 3'(int'(last) + i);
      if (!req_n[idx]) begin
        win = idx;
      end
    end
    return win;
  endfunction
endpackage

// ===== common/exarb_if.sv
/*
  Wires of the shared arbitration bus between a processor end and a host end.
  Assumes the bench resolves wired-AND lines from the enables given here.
*/
interface exarb_if;
  logic [7:0]  peer_request_lines;
  logic        host_request_n;
  logic        host_grant_n;
  logic        host_grant_oe;
  logic        host_back_off_n;
  logic        core_priority_line_in_n;
  logic        core_priority_line_oe;
  logic        dma_priority_line_in_n;
  logic        dma_priority_line_oe;
  logic        priority_pullup_en;
  logic        locked_bus_indication_n;
  logic        master_indicator_n;
  logic        bus_outputs_oe;
  logic        sdram_self_refresh;
  logic [31:0] outstanding_addr;

  modport device (
    input  peer_request_lines, host_request_n, host_back_off_n,
           core_priority_line_in_n, dma_priority_line_in_n,
    output host_grant_n, host_grant_oe, core_priority_line_oe, dma_priority_line_oe,
           priority_pullup_en, locked_bus_indication_n, master_indicator_n,
           bus_outputs_oe, sdram_self_refresh, outstanding_addr
  );
  modport host (
    output host_request_n, host_back_off_n,
    input  host_grant_n, host_grant_oe, bus_outputs_oe, sdram_self_refresh,
           outstanding_addr, master_indicator_n
  );
endinterface

// ===== design/exarb_device.sv
/*
  Processor end of the external bus arbitration: own request line, peer
  watching, host request and grant, back-off, lock and priority lines.
  Assumes peer request lines reach it as one resolved low-active vector and
  that request lines of absent processors idle high.
*/
module exarb_device
  import exarb_pkg::*;
#(
  parameter int SREF_CYCLES = EXARB_SREF_CYCLES
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  input  wire logic [exarb_pkg::EXARB_ID_W-1:0] processor_identifier,
  input  wire logic                         master_strap_in,
  input  wire logic                         want_bus,
  input  wire logic                         xact_active,
  input  wire logic                         xact_done,
  input  wire logic [31:0]                  xact_addr,
  input  wire logic                         lock_req,
  input  wire logic                         core_access,
  input  wire logic                         hp_dma_access,
  input  wire logic                         bg_dma_only,
  output logic                              own_request_n,
  output logic [2:0]                        own_request_index,
  output logic                              master_strap,
  output logic                              owns_bus,
  output logic                              xact_abort,
  output logic                              must_yield,
  exarb_if.device                           bus
);
  import exarb_pkg::*;

  // ----------------------------------------------------------------
  // Reset strap and identifier capture
  // ----------------------------------------------------------------
  logic       strap_done;
  logic [2:0] my_id;
  logic [2:0] last_owner;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done   <= 1'b0;
      master_strap <= 1'b0;
      my_id        <= EXARB_ID_ZERO;
    end else if (!strap_done) begin
      strap_done   <= 1'b1;
      master_strap <= master_strap_in;
      my_id        <= processor_identifier;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  exarb_state_t state;
  exarb_state_t next_state;
  logic [7:0]   peers_n;
  logic [2:0]   winner;
  logic         host_req;
  logic         backoff;
  logic         prio_core;
  logic         prio_dma;
  logic         preempt;
  logic [2:0]   sref_cnt;

  assign host_req  = !bus.host_request_n;
  assign backoff   = !bus.host_back_off_n;
  assign prio_core = !bus.core_priority_line_in_n;
  assign prio_dma  = !bus.dma_priority_line_in_n;
  assign peers_n   = bus.peer_request_lines;
  assign winner    = exarb_next_owner(peers_n, last_owner);
  // Slave priority raised while we only run lower-priority DMA
  assign preempt   = bg_dma_only && ((prio_core && !core_access) || (prio_dma && !hp_dma_access));
  assign must_yield = (state == EXARB_OWN) && (host_req || preempt ||
                      (peers_n != (EXARB_REQ_IDLE & ~(8'h01 << my_id))));
  assign xact_abort = (state == EXARB_OWN) && backoff && xact_active
                      && exarb_is_host_space(xact_addr);

  always_comb begin
    next_state = state;
    unique case (state)
      EXARB_IDLE: begin
        if (!host_req && strap_done && want_bus && winner == my_id && !peers_n[my_id]) begin
          next_state = EXARB_OWN;
        end
      end
      EXARB_OWN: begin
        if (xact_abort) begin
          next_state = host_req ? EXARB_SREF : EXARB_YIELD;
        end else if ((!xact_active || xact_done) && !lock_req) begin
          if (host_req) begin
            next_state = EXARB_SREF;
          end else if (!want_bus || must_yield) begin
            next_state = EXARB_YIELD;
          end
        end
      end
      EXARB_SREF: begin
        if (sref_cnt == 3'(SREF_CYCLES - 1)) begin
          next_state = EXARB_HOSTED;
        end
      end
      EXARB_HOSTED: begin
        if (!host_req) begin
          next_state = EXARB_WAIT;
        end
      end
      EXARB_YIELD: next_state = EXARB_WAIT;
      EXARB_WAIT:  next_state = EXARB_IDLE;
      default:     next_state = EXARB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= EXARB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_owner <= EXARB_ID_ZERO;
    end else if (state == EXARB_IDLE && peers_n != EXARB_REQ_IDLE) begin
      last_owner <= winner;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sref_cnt <= 3'h0;
    end else if (state == EXARB_SREF) begin
      sref_cnt <= sref_cnt + 3'h1;
    end else begin
      sref_cnt <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic grant_drv;
  logic is_master;

  assign is_master = (state == EXARB_OWN) || (state == EXARB_SREF) || (state == EXARB_HOSTED);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      own_request_n     <= 1'b1;
      own_request_index <= EXARB_ID_ZERO;
    end else begin
      own_request_n     <= !(strap_done && want_bus && state != EXARB_HOSTED && state != EXARB_WAIT);
      own_request_index <= my_id;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      owns_bus                 <= 1'b0;
      bus.master_indicator_n   <= 1'b1;
      bus.locked_bus_indication_n <= 1'b1;
      bus.bus_outputs_oe       <= 1'b0;
      bus.sdram_self_refresh   <= 1'b0;
      bus.outstanding_addr     <= 32'h0000_0000;
    end else begin
      owns_bus                 <= next_state == EXARB_OWN;
      bus.master_indicator_n   <= !is_master;
      bus.locked_bus_indication_n <= !(state == EXARB_OWN && lock_req);
      bus.bus_outputs_oe       <= next_state == EXARB_OWN;
      bus.sdram_self_refresh   <= next_state == EXARB_SREF || next_state == EXARB_HOSTED;
      bus.outstanding_addr     <= xact_addr;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_drv <= 1'b0;
    end else begin
      grant_drv <= is_master || next_state == EXARB_HOSTED;
    end
  end

  assign bus.host_grant_oe = grant_drv;
  assign bus.host_grant_n  = !(state == EXARB_HOSTED);
  assign bus.core_priority_line_oe = strap_done && core_access && want_bus;
  assign bus.dma_priority_line_oe  = strap_done && hp_dma_access && want_bus;
  assign bus.priority_pullup_en    = strap_done && my_id == EXARB_ID_ZERO;
endmodule

// ===== design/exarb_host.sv
/*
  Host end of the external bus arbitration: asks for the bus, waits for
  the grant, holds its request while it uses the bus, and backs a master off.
  Resolves the grant seen here from the master's grant level and its enable.
*/
module exarb_host
  import exarb_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic need_bus,
  input  wire logic deadlock,
  output logic      host_owns_bus,
  exarb_if.host     bus
);
  import exarb_pkg::*;

  // ----------------------------------------------------------------
  // Request and back-off
  // ----------------------------------------------------------------
  logic granted;

  assign granted = bus.host_grant_oe && !bus.host_grant_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.host_request_n <= 1'b1;
    end else if (need_bus) begin
      bus.host_request_n <= 1'b0;
    end else begin
      bus.host_request_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.host_back_off_n <= 1'b1;
    end else begin
      bus.host_back_off_n <= !(deadlock && !granted
                               && exarb_is_host_space(bus.outstanding_addr));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_owns_bus <= 1'b0;
    end else begin
      host_owns_bus <= granted && !bus.host_request_n && !bus.bus_outputs_oe;
    end
  end
endmodule

// ===== tb/exarb_props.sv
/*
  Checker for the arbitration wires between processor end and host end.
  Assumes tb_top instantiates it beside the interface, on core_clk.
*/
module exarb_props
  import exarb_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        host_request_n,
  input wire logic        host_grant_n,
  input wire logic        host_grant_oe,
  input wire logic        host_back_off_n,
  input wire logic        locked_bus_indication_n,
  input wire logic        bus_outputs_oe,
  input wire logic        sdram_self_refresh,
  input wire logic [31:0] outstanding_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic gnt     = host_grant_oe && !host_grant_n;
  wire logic host_sp = outstanding_addr[31:28] != EXARB_LOCAL_SPACE;
  // ----------------------------------------
  // Grant, release, self-refresh, back-off and lock
  // ----------------------------------------
  AST_GRANT_HOLD: assert property (gnt && !host_request_n |=> gnt)
    else $error("Grant dropped while host still requests");
  AST_GRANT_DROP: assert property (gnt && host_request_n |-> ##[1:3] host_grant_n)
    else $error("Grant kept after request withdrawn");
  AST_GRANT_REQ: assert property ($fell(host_grant_n) |-> !host_request_n)
    else $error("Grant without host request");
  AST_SREF_FIRST: assert property ($fell(host_grant_n) |-> $past(sdram_self_refresh))
    else $error("Grant before self-refresh");
  AST_GRANT_SREF: assert property (gnt |-> sdram_self_refresh)
    else $error("Self-refresh left during grant");
  AST_SREF_OFF: assert property (sdram_self_refresh |-> !bus_outputs_oe)
    else $error("Bus driven during self-refresh");
  AST_HOST_BACK_OFF_HOST: assert property (!host_back_off_n && bus_outputs_oe && host_sp && !gnt
    |-> ##[1:4] !bus_outputs_oe)
    else $error("Back-off on host space not obeyed");
  AST_LOCK: assert property (!locked_bus_indication_n |-> bus_outputs_oe)
    else $error("Lock shown without bus ownership");
  cover property ($fell(host_grant_n));
  cover property (!host_back_off_n && bus_outputs_oe && host_sp);
  cover property (!locked_bus_indication_n);
endmodule

// ===== tb/tb_top.sv
/*
  Testbench joining the processor end and the host end of the arbiter.
  Assumes one clock and that the bench resolves the wired lines.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import exarb_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic [2:0]  id       = 3'h5;
  logic        strap = 1'b0, want = 1'b0, act = 1'b0, done = 1'b0, lock = 1'b0;
  logic        core = 1'b0, hpdma = 1'b0, bg = 1'b0, need = 1'b0, dl = 1'b0, pcpa = 1'b0;
  logic [31:0] addr = 32'h0;
  logic        own_n, owns, abort, yld, strap_o, host_owns;
  logic [2:0]  idx;
  logic [7:0]  req;
  int          n_mismatch = 0;
  int          total_checks = 0;
  exarb_if bus();
  always #4 core_clk = ~core_clk;
  // ----------------------------------------
  // Wired lines
  // ----------------------------------------
  always_comb begin
    req = 8'hFF;
    req[idx] = own_n;
  end
  assign bus.peer_request_lines      = req;
  assign bus.core_priority_line_in_n = ~(bus.core_priority_line_oe | pcpa);
  assign bus.dma_priority_line_in_n  = ~bus.dma_priority_line_oe;
  exarb_device #(.SREF_CYCLES(4)) i_exarb_device (
    .core_clk(core_clk), .reset_n(reset_n), .processor_identifier(id),
    .master_strap_in(strap), .want_bus(want), .xact_active(act), .xact_done(done),
    .xact_addr(addr), .lock_req(lock), .core_access(core), .hp_dma_access(hpdma),
    .bg_dma_only(bg), .own_request_n(own_n), .own_request_index(idx),
    .master_strap(strap_o), .owns_bus(owns), .xact_abort(abort), .must_yield(yld), .bus(bus)
  );
  exarb_host i_exarb_host (
    .core_clk(core_clk), .reset_n(reset_n), .need_bus(need), .deadlock(dl),
    .host_owns_bus(host_owns), .bus(bus)
  );
  exarb_props i_exarb_props (
    .core_clk(core_clk), .reset_n(reset_n), .host_request_n(bus.host_request_n),
    .host_grant_n(bus.host_grant_n), .host_grant_oe(bus.host_grant_oe),
    .host_back_off_n(bus.host_back_off_n), .locked_bus_indication_n(bus.locked_bus_indication_n),
    .bus_outputs_oe(bus.bus_outputs_oe), .sdram_self_refresh(bus.sdram_self_refresh),
    .outstanding_addr(bus.outstanding_addr)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_for(input int sel, input logic v);
    logic s;
    for (int i = 0; i < 200; i++) begin
      s = sel ? bus.host_grant_n : owns;
      if (s === v) return;
      tick(1);
    end
    n_mismatch++;
    end_sim;
  endtask
  // ----------------------------------------
  // Sequence: id 5 local-space, then id 0 host-space back-off
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 2; k++) begin
      reset_n = 1'b0;
      id = k ? 3'h0 : 3'h5;
      strap = k[0];
      tick(6);
      reset_n = 1'b1;
      tick(2);
      chk(idx, id);
      chk(strap_o, k[0]);
      chk(bus.priority_pullup_en, id == 3'h0);
      want = 1'b1;
      tick(1);
      chk(bus.peer_request_lines, 8'(~(8'h01 << id)));
      wait_for(0, 1'b1);
      tick(1);
      chk(bus.master_indicator_n, 1'b0);
      chk(yld, 1'b0);
      core = 1'b1;
      hpdma = 1'b1;
      lock = 1'b1;
      tick(1);
      chk({bus.core_priority_line_oe, bus.dma_priority_line_oe}, 2'h3);
      chk(bus.locked_bus_indication_n, 1'b0);
      core = 1'b0;
      hpdma = 1'b0;
      bg = 1'b1;
      pcpa = 1'b1;
      tick(1);
      chk(yld, 1'b1);
      bg = 1'b0;
      pcpa = 1'b0;
      lock = 1'b0;
      addr = k ? 32'h1000_0000 : 32'h0000_1000;
      act = 1'b1;
      need = 1'b1;
      dl = 1'b1;
      tick(2);
      chk(abort, k[0]);
      chk(yld, 1'b1);
      tick(1);
      if (k == 0) begin
        tick(5);
        chk(bus.host_grant_n, 1'b1);
        chk(abort, 1'b0);
        done = 1'b1;
        tick(1);
        done = 1'b0;
      end
      wait_for(1, 1'b0);
      act = 1'b0;
      dl = 1'b0;
      chk(bus.bus_outputs_oe, 1'b0);
      chk(bus.sdram_self_refresh, 1'b1);
      chk(bus.host_grant_oe, 1'b1);
      tick(20);
      chk(bus.host_grant_n, 1'b0);
      chk(host_owns, 1'b1);
      need = 1'b0;
      wait_for(1, 1'b1);
      chk(host_owns, 1'b0);
      want = 1'b0;
      tick(4);
    end
    end_sim;
  end
endmodule
